//--- design/scc_mem.sv
// Memory end: command decode, bank states and clock-enable power states
// Function
// RULE_01: Sample all inputs on the rising clock only
// RULE_02: Controller idles both banks before refresh, mode set
// RULE_03: Mode set loads all twelve address bits
// RULE_04: Refresh row comes from internal counter
// RULE_05: Self-refresh ignores everything except clock enable
// RULE_06: Controller activates only idle banks
// RULE_07: Controller reads or writes only active banks
// RULE_08: Burst stop honoured only at full page
// RULE_09: Legality judged from the selected bank's state
// RULE_10: Clock enable low, banks idle: power-down
// RULE_11: Refresh with clock enable falling: self-refresh
// RULE_12: Second activate waits bank-to-bank delay
// RULE_13: Precharge waits minimum row-active time
// RULE_14: Auto-precharge closes bank when burst ends
// RULE_15: Read or write waits row-to-column delay
// RULE_16: Self-refresh exit recovers a row cycle
// RULE_17: Clock enable low in recovery: power-down next
// RULE_18: Clock enable high ends power-down
// RULE_19: Idle decode of refresh, mode set, activate
// RULE_20: Clock enable low elsewhere suspends next cycle
// RULE_21: Suspend holds while low, resumes after rise
// RULE_22: Clock enable rise reactivates inputs
// RULE_23: Controller never issues illegal commands (the controller sends burst stop whatever the burst length)
// RULE_24: Suspend freezes burst counter and bank states
`timescale 1ns/1ps
`default_nettype none

module scc_mem #(
  parameter int BURST_MAX = 4    // Cycles of a fixed burst in this model
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  scc_if.mem               bus,
  output logic [11:0]      o_mode,
  output logic [1:0]       o_bank_open,
  output logic [4:0]       o_pwr_state,
  output logic [10:0]      o_refresh_row,
  output logic             o_illegal,
  output logic [7:0]       o_burst_col
);

  // Refuse burst lengths that the 8-bit beat counter cannot hold
  if (BURST_MAX < 1 || BURST_MAX > 255) $error("BURST_MAX out of range");

  ////////////////////////////////////////////////////////////////////////////
  // Sampled pins and command decode
  logic [3:0]  cmd_q;
  logic [11:0] addr_q;
  logic        cke_q;
  logic        cke_prev_q;
  scc_pkg::scc_pwr_t  pwr_q, pwr_d;
  scc_pkg::scc_bank_t bank_q [2];
  logic [1:0]  auto_q;
  logic [7:0]  left_q [2];
  logic [3:0]  rec_q;
  logic [11:0] mode_q;
  logic [10:0] row_cnt_q;
  logic [7:0]  col_q;
  logic        illegal_q;

  // Register the pins on the rising edge only [RULE_01]
  always_ff @(posedge i_sys_clk) begin
    cmd_q      <= {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n};
    addr_q     <= bus.addr;
    cke_q      <= bus.cke;
    cke_prev_q <= i_sys_rst ? 1'b1 : cke_q;
  end

  wire       sel       = addr_q[scc_pkg::BANK_BIT];  // Bank named by the command [RULE_09]
  wire       both_idle = (bank_q[0] == scc_pkg::BANK_IDLE) && (bank_q[1] == scc_pkg::BANK_IDLE);
  wire       is_nop    = cmd_q[3] || (cmd_q == scc_pkg::CMD_NOP);
  wire       nop_like  = cmd_q[3] || (cmd_q[2] && cmd_q[1]);   // Deselect, NOP or burst stop pattern
  wire       run_pwr   = (pwr_q == scc_pkg::PWR_RUN);
  wire       live      = run_pwr && cke_prev_q && cke_q;       // Commands act this cycle
  wire       full_page = (mode_q[scc_pkg::BL_LSB +: scc_pkg::BL_W] == scc_pkg::BL_FULL_PAGE);
  wire       sel_open  = bank_q[sel] != scc_pkg::BANK_IDLE;
  wire       sel_burst = (bank_q[sel] == scc_pkg::BANK_READ) || (bank_q[sel] == scc_pkg::BANK_WRITE);
  wire       do_act    = live && !cmd_q[3] && cmd_q[2:0] == scc_pkg::CMD_ACTIVATE[2:0];
  wire       do_pre    = live && !cmd_q[3] && cmd_q[2:0] == scc_pkg::CMD_PRECHARGE[2:0];
  wire       do_rd     = live && !cmd_q[3] && cmd_q[2:0] == scc_pkg::CMD_READ[2:0];
  wire       do_wr     = live && !cmd_q[3] && cmd_q[2:0] == scc_pkg::CMD_WRITE[2:0];
  wire       do_bst    = live && !cmd_q[3] && cmd_q[2:0] == scc_pkg::CMD_BURST_STOP[2:0];
  wire       ref_code  = !cmd_q[3] && cmd_q[2:0] == scc_pkg::CMD_REFRESH[2:0];
  // Refresh and mode set only act with both banks idle and clock enable high twice [RULE_19]
  wire       do_ref    = live && both_idle && ref_code;
  wire       do_mrs    = live && both_idle && cmd_q == scc_pkg::CMD_MODE_SET;
  wire       burst_stop_ok = do_bst && full_page && sel_burst;   // [RULE_08]
  wire       enter_sr  = run_pwr && cke_prev_q && !cke_q && both_idle && ref_code;

  // Flag commands that are illegal for the current power or bank state
  wire bad_cmd = ((pwr_q == scc_pkg::PWR_SR_RECOV || (pwr_q == scc_pkg::PWR_SELFREF && cke_q))
                  && !nop_like)
              || (do_act && sel_open) || ((do_rd || do_wr) && !sel_open)
              || (live && !both_idle && (ref_code || cmd_q == scc_pkg::CMD_MODE_SET));

  ////////////////////////////////////////////////////////////////////////////
  // Clock-enable power state machine
  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      scc_pkg::PWR_RUN: begin
        if (cke_prev_q && !cke_q) begin
          if (enter_sr)        pwr_d = scc_pkg::PWR_SELFREF;    // [RULE_11]
          else if (both_idle)  pwr_d = scc_pkg::PWR_POWERDOWN;  // [RULE_10]
          else                 pwr_d = scc_pkg::PWR_SUSPEND;    // [RULE_20]
        end
      end
      // Only clock enable is looked at in power-down and self-refresh [RULE_05]
      scc_pkg::PWR_POWERDOWN: if (cke_q) pwr_d = scc_pkg::PWR_RUN;  // [RULE_18] [RULE_22]
      scc_pkg::PWR_SELFREF:   if (cke_q) pwr_d = scc_pkg::PWR_SR_RECOV; // [RULE_16]
      scc_pkg::PWR_SR_RECOV: begin
        if (!cke_q && nop_like)   pwr_d = scc_pkg::PWR_POWERDOWN;   // [RULE_17]
        else if (rec_q == 4'h0)   pwr_d = scc_pkg::PWR_RUN;         // [RULE_16]
      end
      scc_pkg::PWR_SUSPEND: if (cke_q) pwr_d = scc_pkg::PWR_RUN;    // [RULE_21] [RULE_22]
      default: pwr_d = scc_pkg::PWR_RUN;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) pwr_q <= scc_pkg::PWR_RUN;
    else           pwr_q <= pwr_d;
  end

  // Row-cycle recovery count after self-refresh exit
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst)                         rec_q <= 4'h0;
    else if (pwr_q == scc_pkg::PWR_SELFREF) rec_q <= 4'(scc_pkg::ROW_CYCLE_CYC - 1); // [RULE_16]
    else if (rec_q != 4'h0)                rec_q <= rec_q - 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode register and refresh row counter
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      mode_q    <= scc_pkg::MODE_RST;
      row_cnt_q <= scc_pkg::ROW_CNT_RST;
    end else begin
      if (do_mrs) mode_q <= addr_q;                             // [RULE_03]
      // Internal row advances; address and data pins unused [RULE_04]
      if (do_ref || (pwr_q == scc_pkg::PWR_SELFREF)) row_cnt_q <= row_cnt_q + 11'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-bank state, burst length and auto-precharge; frozen while suspended
  for (genvar b = 0; b < 2; b++) begin : g_bank
    wire hit  = (sel == 1'(b));
    wire done = (bank_q[b] == scc_pkg::BANK_READ || bank_q[b] == scc_pkg::BANK_WRITE)
                && left_q[b] == 8'h01 && !full_page;
    always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
        bank_q[b] <= scc_pkg::BANK_IDLE;
        auto_q[b] <= 1'b0;
        left_q[b] <= 8'h00;
      end else if (live) begin                                  // [RULE_24]
        if (hit && do_act && !sel_open) begin
          bank_q[b] <= scc_pkg::BANK_ACTIVE;
        end else if (do_pre && (hit || addr_q[scc_pkg::AUTOCLOSE_BIT])) begin
          bank_q[b] <= scc_pkg::BANK_IDLE;
          auto_q[b] <= 1'b0;
        end else if (hit && (do_rd || do_wr) && sel_open) begin  // [RULE_09]
          bank_q[b] <= do_rd ? scc_pkg::BANK_READ : scc_pkg::BANK_WRITE;
          auto_q[b] <= addr_q[scc_pkg::AUTOCLOSE_BIT];
          left_q[b] <= 8'(BURST_MAX);
        end else if (hit && burst_stop_ok) begin
          bank_q[b] <= scc_pkg::BANK_ACTIVE;
        end else if (done) begin
          // Auto-precharge closes the bank as the burst completes [RULE_14]
          bank_q[b] <= auto_q[b] ? scc_pkg::BANK_IDLE : scc_pkg::BANK_ACTIVE;
          auto_q[b] <= 1'b0;
        end else if (left_q[b] != 8'h00) begin
          left_q[b] <= left_q[b] - 8'h01;
        end
      end
    end
  end

  // Burst column counter holds during suspend [RULE_24]
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst)              col_q <= 8'h00;
    else if (do_rd || do_wr)    col_q <= addr_q[scc_pkg::COL_W-1:0];
    else if (live && sel_burst) col_q <= col_q + 8'h01;
  end

  // Sticky-free per-cycle illegal flag
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) illegal_q <= 1'b0;
    else           illegal_q <= bad_cmd && !is_nop;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs from flip-flops; bank-open bits decoded from the bank states
  assign o_mode        = mode_q;
  assign o_bank_open   = {bank_q[1] != scc_pkg::BANK_IDLE, bank_q[0] != scc_pkg::BANK_IDLE};
  assign o_pwr_state   = pwr_q;
  assign o_refresh_row = row_cnt_q;
  assign o_illegal     = illegal_q;
  assign o_burst_col   = col_q;

endmodule : scc_mem

`default_nettype wire

//--- design/scc_pkg.sv
// Shared constants and types for the command and clock-enable state control pair
package scc_pkg;

  // Bus widths
  localparam int ADDR_W = 12;
  localparam int BANK_BIT = 11;            // Position of bank_select_bit in the address
  localparam int AUTOCLOSE_BIT = 10;       // Address bit that asks for auto-precharge

  // Clock period and timings, in ns, and derived cycle counts
  localparam int CLK_NS = 100;
  localparam int ROW_CYCLE_NS = 70;        // Refresh and self-refresh recovery time
  localparam int BANK_TO_BANK_ACTIVATE_DELAY_NS = 20;
  localparam int ROW_ACTIVE_MIN_TIME_NS = 45;
  localparam int ROW_TO_COLUMN_DELAY_NS = 20;
  localparam int MRS_GAP_CYC = 2;          // Cycles after mode register set
  localparam int ROW_CYCLE_CYC = (ROW_CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RRD_CYC = (BANK_TO_BANK_ACTIVATE_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int RAS_CYC = (ROW_ACTIVE_MIN_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int RCD_CYC = (ROW_TO_COLUMN_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 4;

  // Mode register fields and reset values
  localparam int BL_LSB = 0;
  localparam int BL_W = 3;
  localparam logic [2:0] BL_FULL_PAGE = 3'h7;
  localparam logic [11:0] MODE_RST = 12'h000;
  localparam int ROW_W = 11;
  localparam logic [10:0] ROW_CNT_RST = 11'h000;
  localparam int COL_W = 8;

  // Command codes on {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_BURST_STOP = 4'h6;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_ACTIVATE = 4'h3;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_MODE_SET = 4'h0;

  // Device-wide power states
  typedef enum logic [4:0] {
    PWR_RUN       = 5'h01,
    PWR_POWERDOWN = 5'h02,
    PWR_SELFREF   = 5'h04,
    PWR_SR_RECOV  = 5'h08,
    PWR_SUSPEND   = 5'h10
  } scc_pwr_t;

  // Per-bank state
  typedef enum logic [3:0] {
    BANK_IDLE   = 4'h1,
    BANK_ACTIVE = 4'h2,
    BANK_READ   = 4'h4,
    BANK_WRITE  = 4'h8
  } scc_bank_t;

  // Controller request kinds on the user side
  typedef enum logic [2:0] {
    REQ_NONE, REQ_ACTIVATE, REQ_READ, REQ_WRITE, REQ_PRECHARGE,
    REQ_REFRESH, REQ_MODE_SET, REQ_BURST_STOP
  } scc_req_t;

endpackage : scc_pkg

//--- design/scc_if.sv
// Command pin bundle between the memory controller and the memory
`timescale 1ns/1ps
`default_nettype none

interface scc_if;
  logic        cke;
  logic        cs_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic [11:0] addr;

  modport ctrl (output cke, output cs_n, output ras_n, output cas_n, output we_n, output addr);
  modport mem  (input cke, input cs_n, input ras_n, input cas_n, input we_n, input addr);
endinterface : scc_if

`default_nettype wire

//--- design/scc_ctrl.sv
// Controller end: issues commands under bank-state and timing limits
`timescale 1ns/1ps
`default_nettype none

module scc_ctrl (
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_req_valid,
  input  wire logic [2:0]  i_req_kind,
  input  wire logic        i_req_bank,
  input  wire logic        i_req_autoclose,
  input  wire logic [10:0] i_req_addr,
  input  wire logic        i_cke_req,
  scc_if.ctrl              bus,
  output logic             o_req_ready,
  output logic             o_req_done
);

  logic [3:0]  cmd_q;
  logic [11:0] addr_q;
  logic        cke_q;
  logic        done_q;
  logic [1:0]  open_q;
  logic [3:0]  rcd_q [2];
  logic [3:0]  ras_q [2];
  logic [3:0]  rrd_q;
  logic [3:0]  gap_q;

  // Legality of the request against tracked bank state and timers
  wire open_sel = open_q[i_req_bank];
  wire ok_act   = !open_sel && (rrd_q == 4'h0);                      // [RULE_06] [RULE_12]
  wire ok_rw    = open_sel && (rcd_q[i_req_bank] == 4'h0);          // [RULE_07] [RULE_15]
  wire ok_pre   = (ras_q[i_req_bank] == 4'h0);                      // [RULE_13]
  wire ok_glob  = (open_q == 2'h0);                                 // [RULE_02]
  wire kind_ok  = (i_req_kind == scc_pkg::REQ_ACTIVATE)   ? ok_act
                : (i_req_kind == scc_pkg::REQ_READ)       ? ok_rw
                : (i_req_kind == scc_pkg::REQ_WRITE)      ? ok_rw
                : (i_req_kind == scc_pkg::REQ_PRECHARGE)  ? ok_pre
                : (i_req_kind == scc_pkg::REQ_REFRESH)    ? ok_glob
                : (i_req_kind == scc_pkg::REQ_MODE_SET)   ? ok_glob
                : (i_req_kind == scc_pkg::REQ_BURST_STOP);
  // Requests other than self-refresh entry issue only while clock enable stays high and no gap is pending [RULE_23]
  wire can_go   = cke_q && i_cke_req && (gap_q == 4'h0);
  wire fire     = i_req_valid && can_go && kind_ok;
  wire [3:0] fire_cmd =
      (i_req_kind == scc_pkg::REQ_ACTIVATE)  ? scc_pkg::CMD_ACTIVATE
    : (i_req_kind == scc_pkg::REQ_READ)      ? scc_pkg::CMD_READ
    : (i_req_kind == scc_pkg::REQ_WRITE)     ? scc_pkg::CMD_WRITE
    : (i_req_kind == scc_pkg::REQ_PRECHARGE) ? scc_pkg::CMD_PRECHARGE
    : (i_req_kind == scc_pkg::REQ_REFRESH)   ? scc_pkg::CMD_REFRESH
    : (i_req_kind == scc_pkg::REQ_MODE_SET)  ? scc_pkg::CMD_MODE_SET
    : (i_req_kind == scc_pkg::REQ_BURST_STOP) ? scc_pkg::CMD_BURST_STOP
    : scc_pkg::CMD_NOP;
  wire [11:0] fire_addr = (i_req_kind == scc_pkg::REQ_MODE_SET) ? {i_req_bank, i_req_addr}
    : (i_req_kind == scc_pkg::REQ_READ || i_req_kind == scc_pkg::REQ_WRITE)
      ? {i_req_bank, i_req_autoclose, i_req_addr[9:0]} : {i_req_bank, i_req_addr};
  // Self-refresh needs refresh code with clock enable falling and idle banks [RULE_11]
  wire sr_fall  = cke_q && !i_cke_req && i_req_valid && ok_glob
                  && (i_req_kind == scc_pkg::REQ_REFRESH);

  // Command pins: NOP unless a request fires; deselect-like while leaving [RULE_16]
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      cmd_q  <= scc_pkg::CMD_NOP;
      addr_q <= 12'h000;
      cke_q  <= 1'b1;
      done_q <= 1'b0;
    end else begin
      cke_q  <= i_cke_req;                                         // [RULE_10] [RULE_21]
      cmd_q  <= fire ? fire_cmd : (sr_fall ? scc_pkg::CMD_REFRESH : scc_pkg::CMD_NOP);
      addr_q <= fire ? fire_addr : addr_q;
      done_q <= fire || sr_fall;
    end
  end

  // Bank tracking and timing counters; burst stop only useful at full page [RULE_08]
  for (genvar b = 0; b < 2; b++) begin : g_trk
    wire me = (i_req_bank == 1'(b));
    always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
        open_q[b] <= 1'b0;
        rcd_q[b]  <= 4'h0;
        ras_q[b]  <= 4'h0;
      end else if (fire && me && i_req_kind == scc_pkg::REQ_ACTIVATE) begin
        open_q[b] <= 1'b1;
        rcd_q[b]  <= 4'(scc_pkg::RCD_CYC);
        ras_q[b]  <= 4'(scc_pkg::RAS_CYC);
      end else if (fire && (me || i_req_addr[10]) && i_req_kind == scc_pkg::REQ_PRECHARGE
                   || fire && me && i_req_autoclose
                      && (i_req_kind == scc_pkg::REQ_READ || i_req_kind == scc_pkg::REQ_WRITE)) begin
        open_q[b] <= 1'b0;
      end else begin
        if (rcd_q[b] != 4'h0) rcd_q[b] <= rcd_q[b] - 4'h1;
        if (ras_q[b] != 4'h0) ras_q[b] <= ras_q[b] - 4'h1;
      end
    end
  end

  // Bank-to-bank activate spacing and post-command gap
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      rrd_q <= 4'h0;
      gap_q <= 4'h0;
    end else begin
      if (fire && i_req_kind == scc_pkg::REQ_ACTIVATE) rrd_q <= 4'(scc_pkg::RRD_CYC);
      else if (rrd_q != 4'h0)                          rrd_q <= rrd_q - 4'h1;
      if (fire && i_req_kind == scc_pkg::REQ_MODE_SET)     gap_q <= 4'(scc_pkg::MRS_GAP_CYC);
      else if (fire && i_req_kind == scc_pkg::REQ_REFRESH) gap_q <= 4'(scc_pkg::ROW_CYCLE_CYC);
      else if (gap_q != 4'h0)                              gap_q <= gap_q - 4'h1;
    end
  end

  assign bus.cke   = cke_q;
  assign bus.cs_n  = cmd_q[3];
  assign bus.ras_n = cmd_q[2];
  assign bus.cas_n = cmd_q[1];
  assign bus.we_n  = cmd_q[0];
  assign bus.addr  = addr_q;
  assign o_req_ready = can_go;
  assign o_req_done  = done_q;

endmodule : scc_ctrl

`default_nettype wire

//--- dv/scc_chk.sv
// Checker of the controller's commands on the joined pin bundle
`timescale 1ns/1ps
`default_nettype none

module scc_chk (
  input wire logic        i_sys_clk,
  input wire logic        i_sys_rst,
  input wire logic        cke,
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic [11:0] addr
);
  logic       cke_q;
  logic [1:0] open_q;
  logic [2:0] bl_q;
  logic [3:0] age_q [2];
  logic [3:0] cmd;
  logic       go, bk, act, col, pre, rfm, burst_stop_cmd;

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  ////////////////////////////////////////////////////////////////////////////////
  // Decode of what the memory takes as a command
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign go  = cke_q & cke;
  assign bk  = addr[11];
  assign act = go & (cmd == scc_pkg::CMD_ACTIVATE);
  assign col = go & ((cmd == scc_pkg::CMD_READ) | (cmd == scc_pkg::CMD_WRITE));
  assign pre = go & (cmd == scc_pkg::CMD_PRECHARGE);
  assign rfm = go & ((cmd == scc_pkg::CMD_REFRESH) | (cmd == scc_pkg::CMD_MODE_SET));
  assign burst_stop_cmd = go & (cmd == scc_pkg::CMD_BURST_STOP);

  // Open banks, burst length and cycles since each bank was opened
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      cke_q  <= 1'b1;
      open_q <= 2'h0;
      bl_q   <= scc_pkg::MODE_RST[2:0];
      age_q  <= '{4'hf, 4'hf};
    end else begin
      cke_q <= cke;
      if (pre && addr[10])
        open_q <= 2'h0;
      else if (pre || (col && addr[10]))
        open_q[bk] <= 1'b0;
      else if (act)
        open_q[bk] <= 1'b1;
      if (go && cmd == scc_pkg::CMD_MODE_SET)
        bl_q <= addr[2:0];
      for (int b = 0; b < 2; b++)
        age_q[b] <= (act && bk == b) ? 4'h1 : age_q[b] + {3'h0, age_q[b] != 4'hf};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Obligations of the controller on the wire
  property p_one_cycle; act | col | pre | rfm | burst_stop_cmd |=> cs_n | (cmd == scc_pkg::CMD_NOP); endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("command held too long");
  property p_idle_first; rfm |-> open_q == 2'h0; endproperty
  a_idle_first: assert property (p_idle_first) else $error("bank open at refresh");
  property p_act_idle; act |-> !open_q[bk]; endproperty
  a_act_idle: assert property (p_act_idle) else $error("activate to open bank");
  property p_col_open; col |-> open_q[bk]; endproperty
  a_col_open: assert property (p_col_open) else $error("column access to idle bank");
  property p_stop_page; burst_stop_cmd |-> bl_q == scc_pkg::BL_FULL_PAGE; endproperty
  a_stop_page: assert property (p_stop_page) else $error("burst stop not full page");
  property p_act_gap; act |-> age_q[!bk] >= scc_pkg::RRD_CYC; endproperty
  a_act_gap: assert property (p_act_gap) else $error("activates too close");
  property p_pre_gap;
    pre |-> age_q[bk] >= scc_pkg::RAS_CYC && (!addr[10] || age_q[!bk] >= scc_pkg::RAS_CYC);
  endproperty
  a_pre_gap: assert property (p_pre_gap) else $error("precharge too early");
  property p_col_gap; col |-> age_q[bk] >= scc_pkg::RCD_CYC; endproperty
  a_col_gap: assert property (p_col_gap) else $error("column access too early");

  // Main scenarios reached
  c_act: cover property (act);
  c_stop: cover property (burst_stop_cmd);
  c_refresh: cover property (rfm);
endmodule : scc_chk

`default_nettype wire

//--- dv/tb_top.sv
// Bench: controller and memory joined, plus a memory on a bench-driven bundle
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, sn) \
  begin \
    n_compared++; \
    if ((sn) !== (ex)) begin \
      fails++; \
      $display("wrong value %s expected %h seen %h", nm, ex, sn); \
    end \
  end

module tb_top;
  logic        sys_clk, sys_rst, req_valid, req_bank, req_ac, cke_req, req_ready, req_done;
  logic [2:0]  req_kind;
  logic [10:0] req_addr, m_row, row;
  logic [11:0] m_mode, b_mode;
  logic [1:0]  m_open, b_open;
  logic [4:0]  m_pwr, b_pwr;
  logic        m_ill, b_ill, ill_seen;
  logic [7:0]  b_col, col;
  int          fails, n_compared;

  scc_if scc_if_i ();
  scc_if scc_if_b ();

  ////////////////////////////////////////////////////////////////////////////////
  // Joined pair with its checker, and a memory on the bench-driven bundle
  scc_ctrl scc_ctrl_i (.i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .i_req_valid(req_valid),
    .i_req_kind(req_kind), .i_req_bank(req_bank), .i_req_autoclose(req_ac),
    .i_req_addr(req_addr), .i_cke_req(cke_req), .bus(scc_if_i), .o_req_ready(req_ready),
    .o_req_done(req_done));
  scc_mem scc_mem_i (.i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .bus(scc_if_i),
    .o_mode(m_mode), .o_bank_open(m_open), .o_pwr_state(m_pwr), .o_refresh_row(m_row),
    .o_illegal(m_ill), .o_burst_col());
  scc_mem scc_mem_b_i (.i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .bus(scc_if_b),
    .o_mode(b_mode), .o_bank_open(b_open), .o_pwr_state(b_pwr), .o_refresh_row(),
    .o_illegal(b_ill), .o_burst_col(b_col));
  scc_chk scc_chk_i (.i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .cke(scc_if_i.cke),
    .cs_n(scc_if_i.cs_n), .ras_n(scc_if_i.ras_n), .cas_n(scc_if_i.cas_n),
    .we_n(scc_if_i.we_n), .addr(scc_if_i.addr));

  // Clock and a sticky record of illegal commands on the joined pair
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (m_ill === 1'b1) ill_seen <= 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic end_sim();
    if (fails == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  // One request to the controller, held until its command goes out
  task automatic req(input logic [2:0] k, input logic bk, input logic ac, input logic [10:0] a);
    int n;
    @(negedge sys_clk);
    {req_kind, req_bank, req_ac, req_addr, req_valid} = {k, bk, ac, a, 1'b1};
    for (n = 0; n < 30 && req_done !== 1'b1; n++)
      @(negedge sys_clk);
    req_valid = 1'b0;
    `CHK("request done", 1'b1, req_done)
  endtask : req

  // One cycle of clock enable, command and address on the bench bundle
  task automatic bop(input logic ck, input logic [3:0] c, input logic [11:0] a);
    @(negedge sys_clk);
    {scc_if_b.cke, scc_if_b.cs_n, scc_if_b.ras_n, scc_if_b.cas_n, scc_if_b.we_n} = {ck, c};
    scc_if_b.addr = a;
  endtask : bop

  // Bounded wait for a power state on either memory
  task automatic pwait(input logic sel, input logic [4:0] ex);
    int n;
    for (n = 0; n < 8 && (sel ? m_pwr : b_pwr) !== ex; n++)
      @(negedge sys_clk);
    `CHK("power state", ex, (sel ? m_pwr : b_pwr))
  endtask : pwait

  // Bounded look for the illegal-command pulse of the bench memory
  task automatic bill(input logic ck);
    logic hit;
    bop(ck, scc_pkg::CMD_NOP, 12'h5a5);
    hit = (b_ill === 1'b1);
    repeat (3) begin
      @(negedge sys_clk);
      hit = hit | (b_ill === 1'b1);
    end
    `CHK("illegal flag", 1'b1, hit)
  endtask : bill

  ////////////////////////////////////////////////////////////////////////////////
  // Joined pair: open, read, close; then an auto-closing read
  task automatic t_bank_cycle();
    int n;
    req(3'h1, 1'b0, 1'b0, 11'h123);
    repeat (2) @(negedge sys_clk);
    `CHK("bank open", 2'h1, m_open)
    req(3'h2, 1'b0, 1'b0, 11'h010);
    req(3'h4, 1'b0, 1'b0, 11'h000);
    repeat (2) @(negedge sys_clk);
    `CHK("bank closed", 2'h0, m_open)
    req(3'h1, 1'b1, 1'b0, 11'h2aa);
    req(3'h2, 1'b1, 1'b1, 11'h420);
    for (n = 0; n < 12 && m_open !== 2'h0; n++)
      @(negedge sys_clk);
    `CHK("auto close", 2'h0, m_open)
  endtask : t_bank_cycle

  // Joined pair: power-down, mode word, refresh row, burst stop at full page
  task automatic t_main_modes();
    @(negedge sys_clk);
    cke_req = 1'b0;
    pwait(1'b1, scc_pkg::PWR_POWERDOWN);
    `CHK("ready", 1'b0, req_ready)
    @(negedge sys_clk);
    cke_req = 1'b1;
    pwait(1'b1, scc_pkg::PWR_RUN);
    req(3'h6, 1'b1, 1'b0, 11'h207);
    repeat (2) @(negedge sys_clk);
    `CHK("mode word", 12'ha07, m_mode)
    req(3'h5, 1'b0, 1'b0, 11'h5a5);
    repeat (2) @(negedge sys_clk);
    row = m_row;
    req(3'h5, 1'b1, 1'b0, 11'h2da);
    repeat (2) @(negedge sys_clk);
    `CHK("refresh row step", row + 11'h001, m_row)
    req(3'h1, 1'b0, 1'b0, 11'h001);
    req(3'h2, 1'b0, 1'b0, 11'h000);
    req(3'h7, 1'b0, 1'b0, 11'h000);
    repeat (6) @(negedge sys_clk);
    `CHK("bank kept after stop", 2'h1, m_open)
    req(3'h4, 1'b0, 1'b1, 11'h400);
    repeat (2) @(negedge sys_clk);
    `CHK("all banks closed", 2'h0, m_open)
  endtask : t_main_modes

  // Bench memory: mode word, power-down that ignores commands, self-refresh
  task automatic t_b_power();
    bop(1'b1, scc_pkg::CMD_MODE_SET, 12'hb47);
    bop(1'b1, scc_pkg::CMD_NOP, 12'h4b8);
    bop(1'b1, scc_pkg::CMD_NOP, 12'h5a5);
    `CHK("bench mode word", 12'hb47, b_mode)
    bop(1'b0, scc_pkg::CMD_NOP, 12'h0f0);
    pwait(1'b0, scc_pkg::PWR_POWERDOWN);
    bop(1'b0, scc_pkg::CMD_MODE_SET, 12'h0f0);
    bop(1'b1, scc_pkg::CMD_MODE_SET, 12'h3c3);
    bop(1'b1, scc_pkg::CMD_NOP, 12'hc3c);
    pwait(1'b0, scc_pkg::PWR_RUN);
    `CHK("mode kept", 12'hb47, b_mode)
    bop(1'b0, scc_pkg::CMD_REFRESH, 12'hfff);
    bop(1'b0, scc_pkg::CMD_MODE_SET, 12'h0f0);
    pwait(1'b0, scc_pkg::PWR_SELFREF);
    bop(1'b1, scc_pkg::CMD_NOP, 12'hf0f);
    bop(1'b0, scc_pkg::CMD_NOP, 12'h0f0);
    pwait(1'b0, scc_pkg::PWR_POWERDOWN);
    `CHK("mode kept in self refresh", 12'hb47, b_mode)
    bop(1'b1, scc_pkg::CMD_NOP, 12'hf0f);
    pwait(1'b0, scc_pkg::PWR_RUN);
    bop(1'b0, scc_pkg::CMD_REFRESH, 12'h000);
    pwait(1'b0, scc_pkg::PWR_SELFREF);
    bop(1'b1, scc_pkg::CMD_READ, 12'hfff);
    bill(1'b1);
    pwait(1'b0, scc_pkg::PWR_RUN);
  endtask : t_b_power

  // Bench memory: bank-selected legality, then clock suspend in a burst
  task automatic t_b_suspend();
    bop(1'b1, scc_pkg::CMD_ACTIVATE, 12'h000);
    bop(1'b1, scc_pkg::CMD_NOP, 12'h5a5);
    bop(1'b1, scc_pkg::CMD_READ, 12'h800);
    bill(1'b1);
    bop(1'b1, scc_pkg::CMD_READ, 12'h010);
    bop(1'b0, scc_pkg::CMD_NOP, 12'hfef);
    pwait(1'b0, scc_pkg::PWR_SUSPEND);
    col = b_col;
    bop(1'b0, scc_pkg::CMD_PRECHARGE, 12'h400);
    bop(1'b0, scc_pkg::CMD_PRECHARGE, 12'hbff);
    bop(1'b0, scc_pkg::CMD_NOP, 12'h400);
    `CHK("suspend held", scc_pkg::PWR_SUSPEND, b_pwr)
    `CHK("burst column frozen", col, b_col)
    `CHK("bank kept in suspend", 2'h1, b_open)
    bop(1'b1, scc_pkg::CMD_NOP, 12'hbff);
    pwait(1'b0, scc_pkg::PWR_RUN);
  endtask : t_b_suspend

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {fails, n_compared, ill_seen, sys_rst, cke_req} = {32'h0, 32'h0, 3'h3};
    {req_valid, req_kind, req_bank, req_ac, req_addr} = '0;
    {scc_if_b.cke, scc_if_b.cs_n, scc_if_b.ras_n, scc_if_b.cas_n, scc_if_b.we_n} = 5'h1f;
    scc_if_b.addr = 12'h000;
    repeat (13) @(negedge sys_clk);
    sys_rst = 1'b0;
    t_bank_cycle();
    t_main_modes();
    t_b_power();
    t_b_suspend();
    `CHK("illegal on joined pair", 1'b0, ill_seen)
    end_sim();
  end

  // Watchdog far past the expected run
  initial begin
    repeat (3000) @(posedge sys_clk);
    fails++;
    end_sim();
  end
endmodule : tb_top

`default_nettype wire
